// >>> frews_pkg.sv
// Constants, types and register map of the flash row erase/write sequencer.
// Assumes a 50 MHz aclk and a 32-bit AXI4-Lite register port.
package frews_pkg;
    // ********************
    // Register map
    // ********************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_UNLOCK = 8'h04;
    localparam logic [7:0] OFF_ADDR_LO = 8'h08;
    localparam logic [7:0] OFF_ADDR_HI = 8'h0c;
    localparam logic [7:0] OFF_DATA_LO = 8'h10;
    localparam logic [7:0] OFF_DATA_HI = 8'h14;
    localparam logic [7:0] OFF_PROT = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] PROT_RESET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Unlock key and latch values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [1:0] KEY_IDLE = 2'h0;
    localparam logic [1:0] KEY_HALF = 2'h1;
    localparam logic [1:0] KEY_ARMED = 2'h2;
    localparam logic [13:0] LATCH_RESET = 14'h3fff;
    localparam int LATCH_N = 32;
    // Protection: ranges guarded per setting of the protect field
    localparam logic [1:0] PROT_NONE = 2'h3;
    localparam logic [1:0] PROT_LOW = 2'h2;
    localparam logic [1:0] PROT_HALF = 2'h1;
    localparam logic [13:0] PROT_LOW_END = 14'h0800;
    localparam logic [13:0] PROT_HALF_END = 14'h2000;
    // ********************
    // Timing
    // ********************
    localparam int CLK_PERIOD_NS = 20;
    localparam int OP_TIME_NS = 2000000;
    localparam int OP_CYCLES_DEF = OP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [19:0] SETUP_LAST = 20'h00001;
    localparam logic [19:0] READ_SLOT = 20'h00001;
    localparam logic [19:0] READ_TAKE = 20'h00002;
    // ********************
    // Types
    // ********************
    typedef enum logic [3:0] {
        FREWS_IDLE = 4'b0001,
        FREWS_SETUP = 4'b0010,
        FREWS_WORK = 4'b0100,
        FREWS_READ = 4'b1000
    } frews_state_e;
    typedef struct packed {
        logic program_space_select;
        logic config_space_select;
        logic latch_load_only;
        logic row_erase_select;
        logic rsvd;
        logic modify_permit;
        logic prog_trigger;
        logic read_trigger;
    } frews_ctrl_s;
    typedef struct packed {
        logic erase;
        logic write;
        logic read;
        logic [13:0] addr;
        logic [13:0] data;
    } frews_flash_s;
endpackage

// >>> frews_latch_block.sv
// Block of 32 word-wide write latches feeding the array programmer.
// Assumes one load or one clear per cycle, never both.
`timescale 1ns/1ps
module frews_latch_block (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [4:0] load_idx,
    input wire logic [13:0] load_data,
    input wire logic clear_all,
    input wire logic [4:0] rd_idx,
    output logic [13:0] rd_data
);
    logic [13:0] lat [frews_pkg::LATCH_N];

    // Latch storage, back to all ones after each programming
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && clear_all)) begin
            for (int i = 0; i < frews_pkg::LATCH_N; i++) begin
                lat[i] <= frews_pkg::LATCH_RESET;
            end
        end else if (ce && load) begin
            lat[load_idx] <= load_data;
        end
    end

    assign rd_data = lat[rd_idx];
endmodule

// >>> frews_sequencer.sv
// Flash self-programming sequencer: row erase, latch load, block program.
// Assumes a flash array that erases/writes on strobes and reads the
// addressed word while its read strobe is high.
`timescale 1ns/1ps
module frews_sequencer #(
    parameter int OP_CYCLES = frews_pkg::OP_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output frews_pkg::frews_flash_s flash_req,
    input wire logic [13:0] flash_rdata,
    output logic cpu_hold
);
    // ********************
    // Bus slave
    // ********************
    logic aw_full, w_full, w_lane, refused, op_prog, rd_take;
    logic [7:0] aw_q, w_q;
    logic [13:0] addr, data;
    logic [19:0] cnt, op_last;
    logic [1:0] key, prot;
    frews_pkg::frews_ctrl_s ctrl;
    frews_pkg::frews_state_e state;

    // Handshake readies, held low while clock enable is low
    assign awready = ce && !aw_full && !bvalid;
    assign wready = ce && !w_full && !bvalid;
    assign arready = ce && !rvalid;

    // Address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 8'h00;
            w_lane <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_full <= 1'b1;
                aw_q <= awaddr;
            end else if (bvalid && bready) begin
                aw_full <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full <= 1'b1;
                w_q <= wdata[7:0];
                w_lane <= wstrb[0];
            end else if (bvalid && bready) begin
                w_full <= 1'b0;
            end
        end
    end
    // Write decode
    logic wr_go, wr_ok, wr_ctrl, wr_unlock, wr_stat;
    frews_pkg::frews_ctrl_s wr_c;
    assign wr_go = ce && aw_full && w_full && !bvalid;
    assign wr_ok = wr_go && w_lane;
    assign wr_c = w_q;
    assign wr_ctrl = wr_ok && aw_q == frews_pkg::OFF_CTRL;
    assign wr_unlock = wr_ok && aw_q == frews_pkg::OFF_UNLOCK;
    assign wr_stat = wr_ok && aw_q == frews_pkg::OFF_STAT;
    // Address map check for both directions
    function automatic logic mapped(input logic [7:0] a);
        mapped = a[1:0] == 2'h0 && a <= frews_pkg::OFF_STAT;
    endfunction
    // Write response, slave error on unmapped offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= frews_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= mapped(aw_q) ? frews_pkg::RESP_OKAY : frews_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    // Read mux; the unlock register reads zero
    logic [7:0] rd_mux;
    assign rd_mux = araddr == frews_pkg::OFF_CTRL ? ctrl :
                    araddr == frews_pkg::OFF_ADDR_LO ? addr[7:0] :
                    araddr == frews_pkg::OFF_ADDR_HI ? {2'h0, addr[13:8]} :
                    araddr == frews_pkg::OFF_DATA_LO ? data[7:0] :
                    araddr == frews_pkg::OFF_DATA_HI ? {2'h0, data[13:8]} :
                    araddr == frews_pkg::OFF_PROT ? {6'h00, prot} :
                    araddr == frews_pkg::OFF_STAT ?
                        {6'h00, refused, state != frews_pkg::FREWS_IDLE} : 8'h00;
    // Read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= frews_pkg::RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= {24'h000000, rd_mux};
                rresp <= mapped(araddr) ? frews_pkg::RESP_OKAY : frews_pkg::RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ********************
    // Trigger qualification
    // ********************
    logic idle, trig, prot_hit, space_ok, start, ld_only, rd_start, op_end;
    logic [13:0] blk_base;
    assign idle = state == frews_pkg::FREWS_IDLE;
    assign blk_base = {addr[13:5], 5'h00};
    assign prot_hit = prot == frews_pkg::PROT_NONE ? 1'b0 :
                      prot == frews_pkg::PROT_LOW ? blk_base < frews_pkg::PROT_LOW_END :
                      prot == frews_pkg::PROT_HALF ? blk_base < frews_pkg::PROT_HALF_END :
                      1'b1;
    assign space_ok = wr_c.program_space_select && !wr_c.config_space_select;
    // Rising trigger with armed key and permit
    assign trig = wr_ctrl && wr_c.prog_trigger && !ctrl.prog_trigger && idle &&
                  key == frews_pkg::KEY_ARMED && ctrl.modify_permit;
    assign start = trig && space_ok && !prot_hit;
    assign ld_only = start && !wr_c.row_erase_select && wr_c.latch_load_only;
    assign rd_start = wr_ctrl && wr_c.read_trigger && idle && space_ok && !trig;
    assign op_end = ce && state == frews_pkg::FREWS_WORK && cnt == op_last;
    assign op_last = 20'(OP_CYCLES - 1);
    assign rd_take = state == frews_pkg::FREWS_READ && cnt == frews_pkg::READ_TAKE;
    // Unlock key tracker; any write other than the next key step disarms
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key <= frews_pkg::KEY_IDLE;
        end else if (wr_go) begin
            if (wr_unlock && w_q == frews_pkg::KEY_FIRST) begin
                key <= frews_pkg::KEY_HALF;
            end else if (wr_unlock && w_q == frews_pkg::KEY_SECOND &&
                         key == frews_pkg::KEY_HALF) begin
                key <= frews_pkg::KEY_ARMED;
            end else begin
                key <= frews_pkg::KEY_IDLE;
            end
        end
    end
    // Control register; only permit is writable while busy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= frews_pkg::CTRL_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl.modify_permit <= wr_c.modify_permit;
            end
            if (wr_ctrl && idle) begin
                ctrl.program_space_select <= wr_c.program_space_select;
                ctrl.config_space_select <= wr_c.config_space_select;
                ctrl.latch_load_only <= wr_c.latch_load_only;
                ctrl.row_erase_select <= wr_c.row_erase_select;
                ctrl.read_trigger <= rd_start;
                ctrl.prog_trigger <= start && !ld_only;
            end
            if (op_end) begin
                ctrl.prog_trigger <= 1'b0;
                ctrl.row_erase_select <= 1'b0;
            end
            if (rd_take) ctrl.read_trigger <= 1'b0;
        end
    end
    // Address, data pair, protection field and refused flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr <= 14'h0000;
            data <= 14'h0000;
            prot <= frews_pkg::PROT_RESET;
            refused <= 1'b0;
        end else if (ce) begin
            if (wr_ok && aw_q == frews_pkg::OFF_ADDR_LO) addr[7:0] <= w_q;
            if (wr_ok && aw_q == frews_pkg::OFF_ADDR_HI) addr[13:8] <= w_q[5:0];
            if (wr_ok && aw_q == frews_pkg::OFF_DATA_LO) data[7:0] <= w_q;
            if (wr_ok && aw_q == frews_pkg::OFF_DATA_HI) data[13:8] <= w_q[5:0];
            if (wr_ok && aw_q == frews_pkg::OFF_PROT) prot <= w_q[1:0];
            if (rd_take) data <= flash_rdata;
            // Set wins over a write-one clear
            if (trig && !start) begin
                refused <= 1'b1;
            end else if (wr_stat && w_q[1]) begin
                refused <= 1'b0;
            end
        end
    end

    // ********************
    // Operation sequencer
    // ********************
    logic [13:0] lat_rd;

    // Latch load on every accepted trigger without row erase select, load-only triggers included
    frews_latch_block u_latch (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .load(start && !wr_c.row_erase_select),
        .load_idx(addr[4:0]), .load_data(data),
        .clear_all(op_end && op_prog),
        .rd_idx(cnt[4:0]), .rd_data(lat_rd)
    );

    // State and cycle counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= frews_pkg::FREWS_IDLE;
            cnt <= 20'h00000;
            op_prog <= 1'b0;
        end else if (ce) begin
            case (state)
                frews_pkg::FREWS_IDLE: begin
                    cnt <= 20'h00000;
                    if (start && !ld_only) begin
                        state <= frews_pkg::FREWS_SETUP;
                        op_prog <= !wr_c.row_erase_select;
                    end else if (rd_start) begin
                        state <= frews_pkg::FREWS_READ;
                    end
                end
                frews_pkg::FREWS_SETUP: begin
                    cnt <= cnt == frews_pkg::SETUP_LAST ? 20'h00000 : cnt + 20'h00001;
                    if (cnt == frews_pkg::SETUP_LAST) state <= frews_pkg::FREWS_WORK;
                end
                frews_pkg::FREWS_WORK: begin
                    cnt <= cnt + 20'h00001;
                    if (op_end) state <= frews_pkg::FREWS_IDLE;
                end
                frews_pkg::FREWS_READ: begin
                    cnt <= cnt + 20'h00001;
                    if (cnt == frews_pkg::READ_TAKE) state <= frews_pkg::FREWS_IDLE;
                end
                default: state <= frews_pkg::FREWS_IDLE;
            endcase
        end
    end

    // Flash strobes: one row erase, or 32 word writes of the block
    frews_pkg::frews_flash_s next_flash;
    logic in_work;
    assign in_work = state == frews_pkg::FREWS_WORK;
    assign next_flash.erase = in_work && !op_prog && cnt == 20'h00000;
    assign next_flash.write = in_work && op_prog && cnt < 20'(frews_pkg::LATCH_N);
    assign next_flash.read = state == frews_pkg::FREWS_READ && cnt == frews_pkg::READ_SLOT;
    assign next_flash.addr = op_prog && in_work ? {addr[13:5], cnt[4:0]} :
                             in_work ? blk_base : addr;
    assign next_flash.data = op_prog ? lat_rd : frews_pkg::LATCH_RESET;
    // Processor held over the array operation and the read slot
    assign cpu_hold = in_work || next_flash.read;

    // Registered strobes toward the array
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_req <= '0;
        end else if (ce) begin
            flash_req <= next_flash;
        end
    end

    // ********************
    // Checks
    // ********************
    sequence setup_seq;
        state == frews_pkg::FREWS_SETUP [*2] ##1 state == frews_pkg::FREWS_WORK;
    endsequence
    sequence read_seq;
        ##1 cpu_hold ##1 flash_req.read;
    endsequence

    key_before_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ctrl.prog_trigger) |-> $past(key) == frews_pkg::KEY_ARMED) else $error("no key");
    permit_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ctrl.prog_trigger) |-> $past(ctrl.modify_permit)) else $error("no permit");
    erase_select_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
        in_work && !op_prog |-> ctrl.row_erase_select) else $error("erase select dropped");
    setup_two_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        $rose(state == frews_pkg::FREWS_SETUP) |-> setup_seq) else $error("setup length");
    stall_length_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        $fell(in_work) |-> $past(cnt) == op_last) else $error("stall ended early");
    load_no_stall_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        ld_only |=> idle && !cpu_hold && !ctrl.prog_trigger) else $error("load stalled");
    latch_blank_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        op_end && op_prog |=> lat_rd == frews_pkg::LATCH_RESET) else $error("latch not blank");
    protect_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        trig && prot_hit |=> idle && refused) else $error("protected address not refused");
    no_erase_prog_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flash_req.write |-> !flash_req.erase) else $error("erase during program");
    row_aligned_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flash_req.erase |-> flash_req.addr[4:0] == 5'h00) else $error("erase not row aligned");
    trig_cleared_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        op_end |=> !ctrl.prog_trigger && idle) else $error("trigger not cleared at end");
    read_slot_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
        $rose(state == frews_pkg::FREWS_READ) |-> read_seq) else $error("read slot misplaced");
endmodule

// >>> frews_flash_model.sv
// Behavioural flash program array: 14-bit words, 32-word rows.
// Assumes one-cycle erase/write/read strobes from the sequencer.
`timescale 1ns/1ps
module frews_flash_model (
    input wire logic aclk,
    input wire frews_pkg::frews_flash_s flash_req,
    output logic [13:0] flash_rdata
);
    logic [13:0] mem [0:16383];
    logic [13:0] last;
    // ********************
    // Array
    // ********************
    // Blank array at power-up
    initial begin
        foreach (mem[i]) mem[i] = 14'h3fff;
        last = 14'h0000;
    end
    // Erase sets a whole aligned row to all ones, programming only clears bits
    always @(posedge aclk) begin
        if (flash_req.erase === 1'h1) begin
            for (int i = 0; i < 32; i++)
                mem[{flash_req.addr[13:5], 5'(i)}] = 14'h3fff;
        end
        if (flash_req.write === 1'h1) begin
            mem[flash_req.addr] = mem[flash_req.addr] & flash_req.data;
        end
        if (flash_req.read === 1'h1) begin
            last <= mem[flash_req.addr];
        end
    end
    // Word shown only under the read strobe, inverted stale value otherwise
    assign flash_rdata = flash_req.read ? mem[flash_req.addr] : ~last;
endmodule

// >>> testbench.sv
// Self-checking bench for the flash sequencer, driven over AXI4-Lite.
// Assumes the design package and the flash model are compiled first.
`timescale 1ns/1ps
module testbench;
    localparam int OP = 64;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, cpu_hold;
    logic [1:0] bresp, rresp;
    logic [13:0] flash_rdata;
    frews_pkg::frews_flash_s flash_req;
    int n_fail = 0, n_tests = 0, n_hold = 0, n_wr = 0, n_er = 0, n_out = 0;
    logic [8:0] row;
    logic [13:0] d [0:3];
    // ********************
    // Design and array
    // ********************
    frews_sequencer #(.OP_CYCLES(OP)) u_frews_sequencer (.aclk(aclk), .aresetn(aresetn),
        .ce(1'h1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .flash_req(flash_req), .flash_rdata(flash_rdata), .cpu_hold(cpu_hold));
    frews_flash_model u_frews_flash_model (.aclk(aclk), .flash_req(flash_req),
        .flash_rdata(flash_rdata));
    always #10 aclk = ~aclk;
    // Count stall cycles and array strobes
    always @(posedge aclk) begin
        if (cpu_hold === 1'h1) n_hold++;
        if (flash_req.write === 1'h1) n_wr++;
        if (flash_req.erase === 1'h1) n_er++;
        if (flash_req.write === 1'h1 && flash_req.addr[13:5] !== row) n_out++;
    end
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tmo();
        n_fail++;
        $display("[ERR] %0t timeout", $time);
        print_verdict();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] q,
                      input logic [1:0] er = frews_pkg::RESP_OKAY);
        int k;
        awaddr <= a;
        wdata <= q;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        chk(bresp, er);
        bready <= 1'h0;
        @(posedge aclk);
        if (k == 50) tmo();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q,
                      input logic [1:0] er = frews_pkg::RESP_OKAY);
        int k;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        q = rdata;
        chk(rresp, er);
        rready <= 1'h0;
        @(posedge aclk);
        if (k == 50) tmo();
    endtask
    // Address and data pairs
    task automatic setad(input logic [13:0] a, input logic [13:0] q);
        wr(frews_pkg::OFF_ADDR_LO, {24'h0, a[7:0]});
        wr(frews_pkg::OFF_ADDR_HI, {26'h0, a[13:8]});
        wr(frews_pkg::OFF_DATA_LO, {24'h0, q[7:0]});
        wr(frews_pkg::OFF_DATA_HI, {26'h0, q[13:8]});
    endtask
    // Control set up, unlock key, then trigger
    task automatic go(input logic [7:0] c);
        wr(frews_pkg::OFF_CTRL, {24'h0, c & 8'hfd});
        wr(frews_pkg::OFF_UNLOCK, 32'h55);
        wr(frews_pkg::OFF_UNLOCK, 32'haa);
        wr(frews_pkg::OFF_CTRL, {24'h0, c});
    endtask
    // Poll control until triggers and erase select drop
    task automatic idle(output logic [31:0] f);
        int k;
        logic [31:0] c;
        rd(frews_pkg::OFF_CTRL, f);
        c = f;
        for (k = 0; k < 100 && (c & 32'h13) != 32'h0; k++) rd(frews_pkg::OFF_CTRL, c);
        if (k == 100) tmo();
    endtask
    task automatic rword(input logic [13:0] a, output logic [13:0] q);
        logic [31:0] lo, hi;
        int h0;
        setad(a, 14'h0);
        h0 = n_hold;
        wr(frews_pkg::OFF_CTRL, 32'h81);
        idle(lo);
        chk(n_hold - h0, 1);
        rd(frews_pkg::OFF_DATA_LO, lo);
        rd(frews_pkg::OFF_DATA_HI, hi);
        q = {hi[5:0], lo[7:0]};
    endtask
    // ********************
    // Scenarios
    // ********************
    initial begin
        #2000000;
        tmo();
    end
    initial begin
        int h0;
        logic [13:0] q;
        v = $urandom(32'h9b33bd9b);
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        // Reset values and unmapped place
        rd(frews_pkg::OFF_PROT, v);
        chk(v, {30'h0, frews_pkg::PROT_RESET});
        rd(frews_pkg::OFF_CTRL, v);
        chk(v, 32'h0);
        rd(8'h20, v, frews_pkg::RESP_SLVERR);
        wr(8'h24, 32'h0, frews_pkg::RESP_SLVERR);
        // Load three latches, then program from the last one
        row = 9'($urandom_range(1, 500));
        for (int i = 0; i < 4; i++) d[i] = 14'($urandom());
        for (int i = 0; i < 3; i++) begin
            setad({row, 5'(i)}, d[i]);
            h0 = n_hold;
            go(8'ha6);
            idle(v);
            chk(n_hold - h0, 0);
        end
        chk(n_wr, 0);
        setad({row, 5'h1f}, d[3]);
        h0 = n_hold;
        go(8'h86);
        idle(v);
        chk(n_hold - h0, OP);
        chk(n_wr, 32);
        chk(n_out + n_er, 0);
        for (int i = 0; i < 5; i++) begin
            rword({row, 5'(i)}, q);
            chk(q, i < 3 ? d[i] : 14'h3fff);
        end
        rword({row, 5'h1f}, q);
        chk(q, d[3]);
        // Next row with only the last latch: others back at blank
        row = row + 9'h1;
        setad({row, 5'h1f}, 14'h0);
        go(8'h86);
        idle(v);
        rword({row, 5'h00}, q);
        chk(q, 14'h3fff);
        // Row erase
        h0 = n_hold;
        go(8'h96);
        idle(v);
        chk(v & 32'h12, 32'h12);
        chk(n_hold - h0, OP);
        chk(n_er, 1);
        rword({row, 5'h1f}, q);
        chk(q, 14'h3fff);
        // Refused starts: broken key, no permit, protected block
        h0 = n_hold;
        wr(frews_pkg::OFF_UNLOCK, 32'h55);
        wr(frews_pkg::OFF_UNLOCK, 32'haa);
        wr(frews_pkg::OFF_DATA_LO, 32'h0);
        wr(frews_pkg::OFF_CTRL, 32'h96);
        go(8'h92);
        wr(frews_pkg::OFF_PROT, 32'h0);
        go(8'h96);
        rd(frews_pkg::OFF_STAT, v);
        chk(v & 32'h2, 32'h2);
        rd(frews_pkg::OFF_CTRL, v);
        chk(v & 32'h3, 32'h0);
        chk(n_hold - h0, 0);
        chk(n_er, 1);
        wr(frews_pkg::OFF_STAT, 32'h2);
        rd(frews_pkg::OFF_STAT, v);
        chk(v, 32'h0);
        print_verdict();
    end
endmodule
